//--- src/diag_conv_pkg.sv
// constants, types and carriers for the diagnostic page responder
// assumes the command parser and the defect-map lookup speak these structs
package diag_conv_pkg;

   localparam logic [7:0] OPCODE_SEND_DIAG = 8'h1D;
   localparam logic [7:0] PAGE_LIST = 8'h00;
   localparam logic [7:0] PAGE_CONV = 8'h40;
   localparam logic [15:0] LIST_PARAM_LEN = 16'h0002;
   localparam logic [15:0] CONV_PARAM_LEN = 16'h000A;
   // whole parameter list lengths the send command must announce
   localparam logic [15:0] LIST_REQ_LEN = 16'h0004;
   localparam logic [15:0] CONV_REQ_LEN = 16'h000E;

   localparam logic [2:0] FMT_LBA = 3'h0;
   localparam logic [2:0] FMT_BFI = 3'h4;
   localparam logic [2:0] FMT_PSA = 3'h5;

   localparam int RESERVED_AREA_BIT = 7;
   localparam int ALT_SECTOR_BIT = 6;
   localparam int ALT_TRACK_BIT = 5;

   localparam logic [31:0] SECTOR_BYTES = 32'h0000_0278;
   localparam logic [31:0] SECTORS_PER_TRACK = 32'h0000_0022;
   localparam logic [31:0] SENTINEL_LBA = 32'hFFFF_FFFF;
   localparam logic [5:0] DIV_LAST_STEP = 6'h1F;

   localparam int BUF_BYTES = 14;
   localparam logic [3:0] LIST_RESP_LEN = 4'h6;
   localparam logic [3:0] CONV_RESP_LEN = 4'hE;
   localparam logic [3:0] EMPTY_RESP_LEN = 4'h4;

   typedef enum logic [1:0] {
      CLASS_PRIMARY,
      CLASS_SPARE_USED,
      CLASS_REASSIGNED,
      CLASS_SPARE_FREE
   } blockClass_e;

   typedef struct packed {
      logic [7:0] opcode;
      logic pageFormat;
      logic selfTestBit;
      logic deviceOfflineBit;
      logic unitOfflineBit;
      logic [15:0] paramLen;
      logic [7:0] pageCode;
      logic [2:0] srcFmt;
      logic [2:0] dstFmt;
      logic [63:0] addr;
   } diagCmd_s;

   typedef struct packed {
      logic [23:0] cyl;
      logic [7:0] head;
      logic [31:0] sector;
   } physLoc_s;

   typedef struct packed {
      logic byLba;
      logic [31:0] lba;
      physLoc_s phys;
   } mapQuery_s;

   typedef struct packed {
      logic [31:0] lba;
      physLoc_s phys;
      blockClass_e cls;
   } mapAnswer_s;

endpackage : diag_conv_pkg

//--- src/sector_divider.sv
// serial divider: byte offset from index to hard sector number
// assumes start is a one-cycle pulse while idle; done pulses 33 cycles later
`timescale 1ns/10ps
`default_nettype none
module sector_divider (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic start,
   input wire logic [31:0] dividend,
   output logic [31:0] quotient,
   output logic done
);
   localparam logic [10:0] DIVISOR = 11'(diag_conv_pkg::SECTOR_BYTES);

   logic busy_q, busy_d;
   logic done_q, done_d;
   logic [5:0] step_q, step_d;
   logic [10:0] rem_q, rem_d;
   logic [31:0] quo_q, quo_d;
   logic [10:0] trial;

   always_comb begin
      busy_d = busy_q;
      done_d = 1'b0;
      step_d = step_q;
      rem_d = rem_q;
      quo_d = quo_q;
      trial = {rem_q[9:0], quo_q[31]};
      if (start && !busy_q) begin
         busy_d = 1'b1;
         step_d = 6'h00;
         rem_d = 11'h000;
         quo_d = dividend;
      end else if (busy_q) begin
         // restoring step, quotient bit shifts in where the dividend leaves
         if (trial >= DIVISOR) begin
            rem_d = trial - DIVISOR;
            quo_d = {quo_q[30:0], 1'b1};
         end else begin
            rem_d = trial;
            quo_d = {quo_q[30:0], 1'b0};
         end
         step_d = step_q + 6'h01;
         if (step_q == diag_conv_pkg::DIV_LAST_STEP) begin
            busy_d = 1'b0;
            done_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         step_q <= 6'h00;
         rem_q <= 11'h000;
         quo_q <= 32'h0000_0000;
      end else begin
         busy_q <= busy_d;
         done_q <= done_d;
         step_q <= step_d;
         rem_q <= rem_d;
         quo_q <= quo_d;
      end
   end

   assign quotient = quo_q;
   assign done = done_q;
endmodule : sector_divider
`default_nettype wire

//--- src/diag_conv_responder.sv
// diagnostic page responder: runs send-diagnostic parameter pages and
// returns the result bytes to a later receive-results request
// assumes a command parser hands over decoded pages and a defect-map
// lookup answers one query at a time on mapReq/mapAck
`timescale 1ns/10ps
`default_nettype none
module diag_conv_responder (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic cmdValid,
   input wire diag_conv_pkg::diagCmd_s cmd,
   input wire logic resetCondition,
   input wire logic readReq,
   input wire logic [15:0] allocLen,
   input wire logic mapAck,
   input wire diag_conv_pkg::mapAnswer_s mapAnswer,
   output logic busy,
   output logic cmdDone,
   output logic cmdError,
   output logic dataValid,
   output logic mapReq,
   output diag_conv_pkg::mapQuery_s mapQuery,
   output logic respValid,
   output logic [7:0] respByte,
   output logic respLast
);
   typedef enum logic [2:0] {ST_IDLE, ST_DIVIDE, ST_MAP, ST_BUILD, ST_SEND} state_e;

   state_e state_q, state_d;
   diag_conv_pkg::diagCmd_s cmd_q, cmd_d;
   diag_conv_pkg::mapAnswer_s ans_q, ans_d;
   diag_conv_pkg::physLoc_s phys_q, phys_d;
   diag_conv_pkg::mapQuery_s query_q, query_d;
   logic [7:0] buf_q [diag_conv_pkg::BUF_BYTES];
   logic [7:0] buf_d [diag_conv_pkg::BUF_BYTES];
   logic [7:0] build [diag_conv_pkg::BUF_BYTES];
   logic [3:0] buildLen, validLen_q, validLen_d;
   logic [3:0] sendLen_q, sendLen_d, sendCnt_q, sendCnt_d, avail;
   logic valid_q, valid_d, busy_q, busy_d, done_q, done_d, err_q, err_d;
   logic mapReq_q, mapReq_d, respValid_q, respValid_d, respLast_q, respLast_d;
   logic [7:0] respByte_q, respByte_d;
   logic divStart_q, divStart_d, divDone;
   logic [31:0] divQuot;
   logic raFlag, asFlag;
   logic [31:0] lbaOut, sectorStart;
   logic [63:0] outAddr;
   logic fmtOk;

   sector_divider divider (
      .clk(clk),
      .rst_b(rst_b),
      .start(divStart_q),
      .dividend(cmd_q.addr[31:0]),
      .quotient(divQuot),
      .done(divDone)
   );

   // only the three documented address forms are accepted
   always_comb begin
      fmtOk = ((cmd.srcFmt == diag_conv_pkg::FMT_LBA) || (cmd.srcFmt == diag_conv_pkg::FMT_BFI)
               || (cmd.srcFmt == diag_conv_pkg::FMT_PSA))
              && ((cmd.dstFmt == diag_conv_pkg::FMT_LBA) || (cmd.dstFmt == diag_conv_pkg::FMT_BFI)
               || (cmd.dstFmt == diag_conv_pkg::FMT_PSA));
   end

   // result page assembly from the latched request, map answer and location
   always_comb begin
      raFlag = 1'b0;
      asFlag = 1'b0;
      case (ans_q.cls)
         diag_conv_pkg::CLASS_PRIMARY: begin
            raFlag = 1'b0;
            asFlag = 1'b0;
         end
         diag_conv_pkg::CLASS_SPARE_USED: begin
            raFlag = 1'b0;
            asFlag = 1'b1;
         end
         diag_conv_pkg::CLASS_REASSIGNED: begin
            raFlag = 1'b1;
            asFlag = 1'b0;
         end
         diag_conv_pkg::CLASS_SPARE_FREE: begin
            raFlag = 1'b1;
            asFlag = 1'b1;
         end
         default: begin
            raFlag = 1'b0;
            asFlag = 1'b0;
         end
      endcase
      // a logical source is always a live block, so only the alternate sector flag speaks
      if (cmd_q.srcFmt == diag_conv_pkg::FMT_LBA) begin
         raFlag = 1'b0;
      end
      sectorStart = phys_q.sector * diag_conv_pkg::SECTOR_BYTES;
      if (cmd_q.srcFmt == diag_conv_pkg::FMT_LBA) begin
         lbaOut = cmd_q.addr[63:32];
      end else if (raFlag) begin
         lbaOut = diag_conv_pkg::SENTINEL_LBA;
      end else begin
         lbaOut = ans_q.lba;
      end
      case (cmd_q.dstFmt)
         diag_conv_pkg::FMT_LBA: outAddr = {lbaOut, 32'h0000_0000};
         diag_conv_pkg::FMT_BFI: outAddr = {phys_q.cyl, phys_q.head, sectorStart};
         default: begin
            if (cmd_q.srcFmt == diag_conv_pkg::FMT_PSA) begin
               outAddr = cmd_q.addr;
            end else begin
               outAddr = {phys_q.cyl, phys_q.head, phys_q.sector};
            end
         end
      endcase
      for (int i = 0; i < diag_conv_pkg::BUF_BYTES; i++) begin
         build[i] = 8'h00;
      end
      if (cmd_q.pageCode == diag_conv_pkg::PAGE_LIST) begin
         build[0] = diag_conv_pkg::PAGE_LIST;
         build[2] = diag_conv_pkg::LIST_PARAM_LEN[15:8];
         build[3] = diag_conv_pkg::LIST_PARAM_LEN[7:0];
         build[4] = diag_conv_pkg::PAGE_LIST;
         build[5] = diag_conv_pkg::PAGE_CONV;
         buildLen = diag_conv_pkg::LIST_RESP_LEN;
      end else begin
         build[0] = diag_conv_pkg::PAGE_CONV;
         build[2] = diag_conv_pkg::CONV_PARAM_LEN[15:8];
         build[3] = diag_conv_pkg::CONV_PARAM_LEN[7:0];
         build[4] = {5'h00, cmd_q.srcFmt};
         build[5] = {raFlag, asFlag, 1'b0, 2'h0, cmd_q.dstFmt};
         for (int i = 0; i < 8; i++) begin
            build[6 + i] = outAddr[63 - 8 * i -: 8];
         end
         buildLen = diag_conv_pkg::CONV_RESP_LEN;
      end
   end

   // bytes on hand for a receive request: the page, or the zero filler
   always_comb begin
      avail = valid_q ? validLen_q : diag_conv_pkg::EMPTY_RESP_LEN;
   end

   always_comb begin
      state_d = state_q;
      cmd_d = cmd_q;
      ans_d = ans_q;
      phys_d = phys_q;
      query_d = query_q;
      buf_d = buf_q;
      validLen_d = validLen_q;
      sendLen_d = sendLen_q;
      sendCnt_d = sendCnt_q;
      valid_d = valid_q;
      busy_d = 1'b0;
      done_d = 1'b0;
      err_d = 1'b0;
      mapReq_d = mapReq_q;
      respValid_d = 1'b0;
      respLast_d = 1'b0;
      respByte_d = 8'h00;
      divStart_d = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (cmdValid && (cmd.opcode == diag_conv_pkg::OPCODE_SEND_DIAG)) begin
               cmd_d = cmd;
               valid_d = 1'b0;
               if (cmd.selfTestBit || (cmd.paramLen == 16'h0000)) begin
                  done_d = 1'b1;
               end else if ((cmd.pageCode == diag_conv_pkg::PAGE_LIST)
                            && (cmd.paramLen == diag_conv_pkg::LIST_REQ_LEN)) begin
                  busy_d = 1'b1;
                  state_d = ST_BUILD;
               end else if ((cmd.pageCode == diag_conv_pkg::PAGE_CONV)
                            && (cmd.paramLen == diag_conv_pkg::CONV_REQ_LEN) && fmtOk) begin
                  busy_d = 1'b1;
                  if (cmd.srcFmt == diag_conv_pkg::FMT_BFI) begin
                     divStart_d = 1'b1;
                     state_d = ST_DIVIDE;
                  end else begin
                     query_d.byLba = (cmd.srcFmt == diag_conv_pkg::FMT_LBA);
                     query_d.lba = cmd.addr[63:32];
                     query_d.phys = cmd.addr;
                     phys_d = cmd.addr;
                     mapReq_d = 1'b1;
                     state_d = ST_MAP;
                  end
               end else begin
                  err_d = 1'b1;
                  done_d = 1'b1;
               end
            end else if (readReq && (allocLen != 16'h0000)) begin
               busy_d = 1'b1;
               sendCnt_d = 4'h0;
               sendLen_d = (allocLen < {12'h000, avail}) ? allocLen[3:0] : avail;
               state_d = ST_SEND;
            end
         end
         ST_DIVIDE: begin
            busy_d = 1'b1;
            if (divDone) begin
               if (divQuot >= diag_conv_pkg::SECTORS_PER_TRACK) begin
                  err_d = 1'b1;
                  done_d = 1'b1;
                  busy_d = 1'b0;
                  state_d = ST_IDLE;
               end else begin
                  phys_d = {cmd_q.addr[63:32], divQuot};
                  query_d.byLba = 1'b0;
                  query_d.lba = 32'h0000_0000;
                  query_d.phys = {cmd_q.addr[63:32], divQuot};
                  mapReq_d = 1'b1;
                  state_d = ST_MAP;
               end
            end
         end
         ST_MAP: begin
            busy_d = 1'b1;
            if (mapAck) begin
               mapReq_d = 1'b0;
               ans_d = mapAnswer;
               if (query_q.byLba) begin
                  phys_d = mapAnswer.phys;
               end
               state_d = ST_BUILD;
            end
         end
         ST_BUILD: begin
            buf_d = build;
            validLen_d = buildLen;
            valid_d = 1'b1;
            done_d = 1'b1;
            state_d = ST_IDLE;
         end
         ST_SEND: begin
            busy_d = 1'b1;
            respValid_d = 1'b1;
            respByte_d = valid_q ? buf_q[sendCnt_q] : 8'h00;
            sendCnt_d = sendCnt_q + 4'h1;
            if (sendCnt_q == (sendLen_q - 4'h1)) begin
               respLast_d = 1'b1;
               busy_d = 1'b0;
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
      // a bus reset drops work in flight, except a division the divider has begun, along with the stored page
      if (resetCondition) begin
         state_d = ST_IDLE;
         valid_d = 1'b0;
         mapReq_d = 1'b0;
         busy_d = 1'b0;
         done_d = 1'b0;
         err_d = 1'b0;
         respValid_d = 1'b0;
         respLast_d = 1'b0;
         respByte_d = 8'h00;
         divStart_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ST_IDLE;
         cmd_q <= '0;
         ans_q <= '0;
         phys_q <= '0;
         query_q <= '0;
         for (int i = 0; i < diag_conv_pkg::BUF_BYTES; i++) begin
            buf_q[i] <= 8'h00;
         end
         validLen_q <= 4'h0;
         sendLen_q <= 4'h0;
         sendCnt_q <= 4'h0;
         valid_q <= 1'b0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         err_q <= 1'b0;
         mapReq_q <= 1'b0;
         respValid_q <= 1'b0;
         respLast_q <= 1'b0;
         respByte_q <= 8'h00;
         divStart_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cmd_q <= cmd_d;
         ans_q <= ans_d;
         phys_q <= phys_d;
         query_q <= query_d;
         buf_q <= buf_d;
         validLen_q <= validLen_d;
         sendLen_q <= sendLen_d;
         sendCnt_q <= sendCnt_d;
         valid_q <= valid_d;
         busy_q <= busy_d;
         done_q <= done_d;
         err_q <= err_d;
         mapReq_q <= mapReq_d;
         respValid_q <= respValid_d;
         respLast_q <= respLast_d;
         respByte_q <= respByte_d;
         divStart_q <= divStart_d;
      end
   end

   assign busy = busy_q;
   assign cmdDone = done_q;
   assign cmdError = err_q;
   assign dataValid = valid_q;
   assign mapReq = mapReq_q;
   assign mapQuery = query_q;
   assign respValid = respValid_q;
   assign respByte = respByte_q;
   assign respLast = respLast_q;

   // helper: bytes already shown in the current reply
   logic [3:0] beats_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         beats_q <= 4'h0;
      end else if (respLast_q || !respValid_q) begin
         beats_q <= 4'h0;
      end else begin
         beats_q <= beats_q + 4'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b || resetCondition);

   chk_list_page: assert property (
      state_q == ST_BUILD && cmd_q.pageCode == diag_conv_pkg::PAGE_LIST
      |=> buf_q[0] == 8'h00 && buf_q[3] == 8'h02 && buf_q[4] == 8'h00 && buf_q[5] == 8'h40
          && validLen_q == 4'h6)
      else $error("page list reply malformed");
   chk_conv_header: assert property (
      state_q == ST_BUILD && cmd_q.pageCode == diag_conv_pkg::PAGE_CONV
      |=> buf_q[0] == 8'h40 && buf_q[1] == 8'h00 && {buf_q[2], buf_q[3]} == 16'h000A)
      else $error("conversion header malformed");
   chk_format_echo: assert property (
      state_q == ST_BUILD && cmd_q.pageCode == diag_conv_pkg::PAGE_CONV
      |=> buf_q[4][2:0] == $past(cmd_q.srcFmt) && buf_q[5][2:0] == $past(cmd_q.dstFmt))
      else $error("format codes not echoed");
   chk_free_spare: assert property (
      state_q == ST_BUILD && cmd_q.pageCode == diag_conv_pkg::PAGE_CONV
      && cmd_q.srcFmt != diag_conv_pkg::FMT_LBA && ans_q.cls == diag_conv_pkg::CLASS_SPARE_FREE
      |=> buf_q[5][7:5] == 3'b110)
      else $error("unused spare flags wrong");
   chk_lba_sentinel: assert property (
      state_q == ST_BUILD && cmd_q.pageCode == diag_conv_pkg::PAGE_CONV
      && cmd_q.dstFmt == diag_conv_pkg::FMT_LBA && raFlag
      |=> {buf_q[6], buf_q[7], buf_q[8], buf_q[9]} == 32'hFFFF_FFFF)
      else $error("sentinel address missing");
   chk_lba_fill: assert property (
      state_q == ST_BUILD && cmd_q.pageCode == diag_conv_pkg::PAGE_CONV
      && cmd_q.dstFmt == diag_conv_pkg::FMT_LBA
      |=> {buf_q[10], buf_q[11], buf_q[12], buf_q[13]} == 32'h0000_0000)
      else $error("logical result not zero filled");
   chk_sector_start: assert property (
      state_q == ST_BUILD && cmd_q.pageCode == diag_conv_pkg::PAGE_CONV
      && cmd_q.dstFmt == diag_conv_pkg::FMT_BFI
      |=> {buf_q[10], buf_q[11], buf_q[12], buf_q[13]} == 32'($past(phys_q.sector) * 632))
      else $error("sector start offset wrong");
   chk_empty_zero: assert property (
      respValid_q && !valid_q |-> respByte_q == 8'h00 && sendLen_q <= 4'h4)
      else $error("filler byte not zero");
   chk_reply_length: assert property (
      respLast_q |-> beats_q == sendLen_q - 4'h1)
      else $error("reply length wrong");
   chk_valid_kept: assert property (
      valid_q && !(state_q == ST_IDLE && cmdValid) |=> valid_q)
      else $error("stored reply lost");
endmodule : diag_conv_responder
`default_nettype wire

//--- bench/map_model.sv
// behavioural defect-map lookup answering the responder's queries
// assumes mapReq stays high until the cycle after mapAck
`timescale 1ns/10ps
`default_nettype none
module map_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic mapReq,
   input wire diag_conv_pkg::mapQuery_s mapQuery,
   input wire diag_conv_pkg::blockClass_e cls,
   input wire logic [3:0] delay,
   output logic mapAck,
   output diag_conv_pkg::mapAnswer_s mapAnswer
);
   logic [3:0] waitCnt_q;
   logic served_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         waitCnt_q <= 4'h0;
         served_q <= 1'b0;
         mapAck <= 1'b0;
         mapAnswer <= '0;
      end else begin
         mapAck <= 1'b0;
         // lines toggle off the strobe so stale data never looks valid
         mapAnswer <= ~mapAnswer;
         if (!mapReq) begin
            served_q <= 1'b0;
            waitCnt_q <= 4'h0;
         end else if (!served_q && waitCnt_q == delay) begin
            mapAck <= 1'b1;
            served_q <= 1'b1;
            mapAnswer <= '{mapQuery.byLba ? mapQuery.lba : 32'h0000_1234,
                           mapQuery.phys, cls};
         end else if (!served_q) begin
            waitCnt_q <= waitCnt_q + 4'h1;
         end
      end
   end
endmodule : map_model
`default_nettype wire

//--- bench/diag_conv_responder_test.sv
// self-checking bench for the diagnostic page responder
// assumes the map model answers every query after a set delay
`timescale 1ns/10ps
`default_nettype none
module diag_conv_responder_test;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic cmdValid = 1'b0;
   diag_conv_pkg::diagCmd_s cmd = '0;
   logic resetCondition = 1'b0;
   logic readReq = 1'b0;
   logic [15:0] allocLen = 16'h0000;
   logic mapAck, busy, cmdDone, cmdError, dataValid, mapReq;
   logic respValid, respLast, lastErr;
   logic [7:0] respByte;
   diag_conv_pkg::mapQuery_s mapQuery;
   diag_conv_pkg::mapAnswer_s mapAnswer;
   diag_conv_pkg::blockClass_e cls = diag_conv_pkg::CLASS_PRIMARY;
   logic [3:0] delay = 4'h1;
   int failCount = 0;
   int checkCount = 0;
   always #2.5 clk = ~clk;
   diag_conv_responder i_diag_conv_responder (.clk(clk), .rst_b(rst_b),
      .cmdValid(cmdValid), .cmd(cmd), .resetCondition(resetCondition),
      .readReq(readReq), .allocLen(allocLen), .mapAck(mapAck),
      .mapAnswer(mapAnswer), .busy(busy), .cmdDone(cmdDone),
      .cmdError(cmdError), .dataValid(dataValid), .mapReq(mapReq),
      .mapQuery(mapQuery), .respValid(respValid), .respByte(respByte),
      .respLast(respLast));
   map_model i_map_model (.clk(clk), .rst_b(rst_b), .mapReq(mapReq),
      .mapQuery(mapQuery), .cls(cls), .delay(delay), .mapAck(mapAck),
      .mapAnswer(mapAnswer));
   task check(input logic [7:0] got, input logic [7:0] exp);
      checkCount++;
      if (got !== exp) begin
         failCount++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task sendCmd(input logic [7:0] page, input logic [15:0] len,
                input logic [2:0] src, input logic [2:0] dst, input logic [63:0] addr);
      @(negedge clk);
      cmd = '{diag_conv_pkg::OPCODE_SEND_DIAG, 1'b1, 1'b0, 1'b0, 1'b0,
              len, page, src, dst, addr};
      cmdValid = 1'b1;
      @(negedge clk);
      cmdValid = 1'b0;
      repeat (200) begin
         if (cmdDone === 1'b1) break;
         @(negedge clk);
      end
      check({7'h00, cmdDone}, 8'h01);
      lastErr = cmdError;
   endtask : sendCmd
   task readCheck(input logic [15:0] alloc, input logic [111:0] expV, input int n);
      int k;
      k = 0;
      @(negedge clk);
      readReq = 1'b1;
      allocLen = alloc;
      @(negedge clk);
      readReq = 1'b0;
      repeat (20) begin
         if (respValid === 1'b1) begin
            check(respByte, expV[111 - 8 * k -: 8]);
            if (k == n - 1) check({7'h00, respLast}, 8'h01);
            k++;
         end
         @(negedge clk);
      end
      check(k[7:0], n[7:0]);
   endtask : readCheck
   task testList;
      readCheck(16'h0006, '0, 4);
      sendCmd(8'h00, 16'h0004, 3'h0, 3'h0, 64'h0);
      check({7'h00, dataValid}, 8'h01);
      readCheck(16'h0003, '0, 3);
      readCheck(16'h0010, {48'h0000_0002_0040, 64'h0}, 6);
      check({7'h00, busy}, 8'h00);
      $display("test list done");
   endtask : testList
   task testLba;
      cls = diag_conv_pkg::CLASS_SPARE_USED;
      delay = 4'h6;
      sendCmd(8'h40, 16'h000E, 3'h0, 3'h0, {32'h0000_1A2B, 32'h0});
      readCheck(16'h0020, {40'h4000_000A_00, 8'h40, 32'h0000_1A2B, 32'h0},
                14);
      check({7'h00, mapReq}, 8'h00);
      $display("test lba done");
   endtask : testLba
   task testPhys;
      cls = diag_conv_pkg::CLASS_REASSIGNED;
      delay = 4'h0;
      sendCmd(8'h40, 16'h000E, 3'h5, 3'h0, {24'h000010, 8'h02, 32'h5});
      readCheck(16'h000E, {40'h4000_000A_05, 8'h80, 32'hFFFF_FFFF, 32'h0},
                14);
      cls = diag_conv_pkg::CLASS_SPARE_FREE;
      // offset 3 sectors of 632 bytes plus 10
      sendCmd(8'h40, 16'h000E, 3'h4, 3'h5, {24'h000007, 8'h01, 32'h0772});
      readCheck(16'h000E, {40'h4000_000A_04, 8'hC5, 32'h0000_0701, 32'h3},
                14);
      // offset of sector 34 lies past the end of the track
      sendCmd(8'h40, 16'h000E, 3'h4, 3'h5, {24'h000007, 8'h01, 32'h53F0});
      check({7'h00, lastErr}, 8'h01);
      $display("test phys done");
   endtask : testPhys
   task testAbort;
      sendCmd(8'h40, 16'h000E, 3'h1, 3'h0, 64'h0);
      check({7'h00, lastErr}, 8'h01);
      readCheck(16'h0006, '0, 4);
      sendCmd(8'h00, 16'h0004, 3'h0, 3'h0, 64'h0);
      @(negedge clk);
      resetCondition = 1'b1;
      @(negedge clk);
      resetCondition = 1'b0;
      check({7'h00, dataValid}, 8'h00);
      readCheck(16'h0006, '0, 4);
      $display("test abort done");
   endtask : testAbort
   task completeRun;
      $display("checks %0d mismatches %0d", checkCount, failCount);
      if (failCount == 0 && checkCount > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : completeRun
   initial begin
      repeat (16) @(negedge clk);
      rst_b = 1'b1;
      testList;
      testLba;
      testPhys;
      testAbort;
      completeRun;
   end
   // whole run needs well under 2000 cycles
   initial begin
      #100000;
      failCount++;
      completeRun;
   end
endmodule : diag_conv_responder_test
`default_nettype wire
